//--- core/bcc_top.v
// What this block does
// - The 3-bit wait field inserts 2 times its code in bus states, none for code 0, reset none.
// - Each inserted wait state lasts half of one cpu clock cycle.
// - Clock select 1 runs the cpu from the fast oscillator, 0 from the slow one, read/write.
// - Clock select cannot be written to 0 while the slow oscillator is off.
// - Clock select cannot be written to 1 while the fast oscillator is off.
// - Fast oscillator enable switches it, resets to 1, cannot clear while on the fast clock.
// - Slow oscillator enable switches it, resets to 1, cannot clear on slow clock or watchdog.
// - All interrupts including the non-maskable one stay blocked until both registers are written.
// - Bit 7 selects expansion bus mode when 1, bit 6 selects maximum cpu mode when 1.
// - Single chip mode is allowed only with the internal rom strap, else expansion is forced.
// - Reset gives single chip minimum with internal rom, expansion minimum otherwise.
// - Chip-enable control bits 0 to 3 route their pin to the chip enable or the output port.
// - With external program the first chip-enable bit is held at 1 and read-only.
// - First chip-enable bit resets to 0 for internal rom and 1 for external program; others 0.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.vh"

module bcc_top (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// strap and system inputs
	input wire int_rom_strap,
	input wire watchdog_enable,
	// external bus cycle timing
	input wire ext_access_start,
	input wire cpu_half_tick,
	output wire ext_bus_wait,
	// chip enable and port pins
	input wire [3:0] chip_sel_n_in,
	input wire [3:0] general_output_port_pins,
	output reg [3:0] chip_sel_pin,
	// mode and clock outputs
	output reg bus_mode_select,
	output reg cpu_space_mode_select,
	output reg cpu_clock_select,
	output reg fast_osc_enable,
	output reg slow_osc_enable,
	output reg irq_release
);

reg strap_taken;
reg ext_prog;
reg [3:0] chip_sel_out_en;
reg [2:0] wait_sel;
reg written_mode;
reg written_wclk;
reg dp_write;
reg dp_mode;
reg dp_wclk;
reg next_sel;
reg next_fast;
reg next_slow;
wire addr_phase;
wire take;
wire hit_mode;
wire hit_wclk;
wire hit_stat;
wire rd_stall;
wire [7:0] wbyte;
wire [7:0] mode_rd;
wire [7:0] wclk_rd;
wire [7:0] stat_rd;

////////////////////////////////////////////////////////////////////////
// address decode
assign addr_phase = hsel && (htrans == `BCC_HTRANS_NONSEQ);
assign hit_mode = ({haddr[31:2], 2'b00} == `BCC_ADDR_MODE);
assign hit_wclk = ({haddr[31:2], 2'b00} == `BCC_ADDR_WCLK);
assign hit_stat = ({haddr[31:2], 2'b00} == `BCC_ADDR_STAT);

// a read right behind a write waits one cycle so it sees the new value
assign rd_stall = addr_phase && !hwrite && dp_write;
assign hreadyout = strap_taken && !rd_stall;
assign take = addr_phase && hready && hreadyout;
assign hresp = `BCC_HRESP_OKAY;
assign wbyte = hwdata[7:0];

////////////////////////////////////////////////////////////////////////
// readback images
assign mode_rd = {bus_mode_select, cpu_space_mode_select, 2'b00, chip_sel_out_en};
// bit 3 is tied low
assign wclk_rd = {1'b0, wait_sel, 1'b0, cpu_clock_select, fast_osc_enable,
	slow_osc_enable};
assign stat_rd = {5'h00, ext_bus_wait, ext_prog, irq_release};

////////////////////////////////////////////////////////////////////////
// data phase tracking for writes
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		dp_write <= 1'b0;
		dp_mode <= 1'b0;
		dp_wclk <= 1'b0;
	end else if (take) begin
		dp_write <= hwrite;
		dp_mode <= hwrite && hit_mode;
		dp_wclk <= hwrite && hit_wclk;
	end else begin
		// one cycle only, so a stalled read cannot hold a write open forever
		dp_write <= 1'b0;
		dp_mode <= 1'b0;
		dp_wclk <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// read data registered at the address phase, unmapped reads zero
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h00000000;
	end else if (take && !hwrite) begin
		if (hit_mode) begin
			hrdata <= {24'h000000, mode_rd};
		end else if (hit_wclk) begin
			hrdata <= {24'h000000, wclk_rd};
		end else if (hit_stat) begin
			hrdata <= {24'h000000, stat_rd};
		end else begin
			hrdata <= 32'h00000000;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// strap is caught on the first edge after reset release
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		strap_taken <= 1'b0;
		ext_prog <= 1'b0;
	end else if (!strap_taken) begin
		strap_taken <= 1'b1;
		ext_prog <= !int_rom_strap;
	end
end

////////////////////////////////////////////////////////////////////////
// bus mode, cpu mode and chip enable controls
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		bus_mode_select <= 1'b0;
		cpu_space_mode_select <= 1'b0;
		chip_sel_out_en <= 4'h0;
	end else if (!strap_taken) begin
		// reset values depend on the strap, minimum cpu mode always
		bus_mode_select <= !int_rom_strap;
		cpu_space_mode_select <= 1'b0;
		chip_sel_out_en <= {`BCC_RST_CE_HI, !int_rom_strap};
	end else if (dp_mode) begin
		// single chip not possible without internal rom
		bus_mode_select <= wbyte[`BCC_MODE_BUS] | ext_prog;
		cpu_space_mode_select <= wbyte[`BCC_MODE_CPU];
		chip_sel_out_en[`BCC_MODE_CE_HI:1] <= wbyte[`BCC_MODE_CE_HI:1];
		chip_sel_out_en[`BCC_MODE_CE0] <= wbyte[`BCC_MODE_CE0] | ext_prog;
	end
end

////////////////////////////////////////////////////////////////////////
// clock interlocks judged against the values before the write
always @* begin
	next_sel = cpu_clock_select;
	next_fast = fast_osc_enable;
	next_slow = slow_osc_enable;
	// going slow needs the slow oscillator running
	if (!wbyte[`BCC_WCLK_SEL] && slow_osc_enable) begin
		next_sel = 1'b0;
	end
	// going fast needs the fast oscillator running
	if (wbyte[`BCC_WCLK_SEL] && fast_osc_enable) begin
		next_sel = 1'b1;
	end
	// fast oscillator cannot stop under the running cpu
	if (wbyte[`BCC_WCLK_FAST] || !cpu_clock_select) begin
		next_fast = wbyte[`BCC_WCLK_FAST];
	end
	// slow oscillator also feeds the watchdog
	if (wbyte[`BCC_WCLK_SLOW] || (cpu_clock_select && !watchdog_enable)) begin
		next_slow = wbyte[`BCC_WCLK_SLOW];
	end
end

////////////////////////////////////////////////////////////////////////
// wait and clock control register
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wait_sel <= `BCC_RST_WAIT;
		cpu_clock_select <= `BCC_RST_SEL;
		fast_osc_enable <= `BCC_RST_FAST;
		slow_osc_enable <= `BCC_RST_SLOW;
	end else if (dp_wclk) begin
		wait_sel <= wbyte[`BCC_WCLK_WT_HI:`BCC_WCLK_WT_LO];
		cpu_clock_select <= next_sel;
		fast_osc_enable <= next_fast;
		slow_osc_enable <= next_slow;
	end
end

////////////////////////////////////////////////////////////////////////
// interrupt release once both registers have seen a write
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		written_mode <= 1'b0;
		written_wclk <= 1'b0;
		irq_release <= 1'b0;
	end else begin
		if (dp_mode) begin
			written_mode <= 1'b1;
		end
		if (dp_wclk) begin
			written_wclk <= 1'b1;
		end
		// only a reset blocks interrupts again
		irq_release <= (written_mode || dp_mode) && (written_wclk || dp_wclk);
	end
end

////////////////////////////////////////////////////////////////////////
// pin mux: chip enable or general output port per pin
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
		always @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				chip_sel_pin[gi] <= 1'b1;
			end else if (chip_sel_out_en[gi]) begin
				chip_sel_pin[gi] <= chip_sel_n_in[gi];
			end else begin
				chip_sel_pin[gi] <= general_output_port_pins[gi];
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// wait state generation for external bus cycles
bcc_wait_gen u_wait (
	.hclk(hclk),
	.hresetn(hresetn),
	.wait_code(wait_sel),
	.access_start(ext_access_start),
	.half_tick(cpu_half_tick),
	.bus_wait(ext_bus_wait)
);

endmodule
`default_nettype wire

//--- common/bcc_map.vh
`ifndef BCC_MAP_VH
`define BCC_MAP_VH

// register byte addresses
`define BCC_ADDR_MODE 32'h0000FF00
`define BCC_ADDR_WCLK 32'h0000FF04
`define BCC_ADDR_STAT 32'h0000FF08

// mode register fields
`define BCC_MODE_BUS 7
`define BCC_MODE_CPU 6
`define BCC_MODE_CE0 0
`define BCC_MODE_CE_HI 3

// wait and clock register fields
`define BCC_WCLK_WT_HI 6
`define BCC_WCLK_WT_LO 4
`define BCC_WCLK_SEL 2
`define BCC_WCLK_FAST 1
`define BCC_WCLK_SLOW 0

// status register fields
`define BCC_STAT_IRQ_OK 0
`define BCC_STAT_EXT_PROG 1
`define BCC_STAT_WAITING 2

// reset values
`define BCC_RST_WAIT 3'h0
`define BCC_RST_SEL 1'h1
`define BCC_RST_FAST 1'h1
`define BCC_RST_SLOW 1'h1
`define BCC_RST_CE_HI 3'h0

// wait timing: each wait state is one half cpu clock cycle
`define BCC_WAIT_STATES_PER_CODE 2
`define BCC_WAIT_CNT_W 4

// ahb codes
`define BCC_HTRANS_NONSEQ 2'h2
`define BCC_HRESP_OKAY 1'h0

`endif

//--- core/bcc_wait_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.vh"

module bcc_wait_gen (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// configuration
	input wire [2:0] wait_code,
	// bus cycle control
	input wire access_start,
	input wire half_tick,
	output reg bus_wait
);

reg [`BCC_WAIT_CNT_W-1:0] remain;
wire [`BCC_WAIT_CNT_W-1:0] load_val;

// two states per code step, so code 7 gives 14 and code 0 none
assign load_val = {wait_code, 1'b0};

////////////////////////////////////////////////////////////////////////
// state counter, one count per half cpu clock
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		remain <= {`BCC_WAIT_CNT_W{1'b0}};
		bus_wait <= 1'b0;
	end else if (access_start) begin
		remain <= load_val;
		bus_wait <= (load_val != {`BCC_WAIT_CNT_W{1'b0}});
	end else if (half_tick && remain != {`BCC_WAIT_CNT_W{1'b0}}) begin
		// a state lasts exactly one half-cycle tick
		remain <= remain - {{(`BCC_WAIT_CNT_W-1){1'b0}}, 1'b1};
		bus_wait <= (remain != {{(`BCC_WAIT_CNT_W-1){1'b0}}, 1'b1});
	end
end

endmodule
`default_nettype wire

//--- verification/bcc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// watches clock interlocks, strap modes and wait timing at the pins
module bcc_top_assertions (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// system inputs
	input wire int_rom_strap,
	input wire watchdog_enable,
	input wire ext_access_start,
	input wire cpu_half_tick,
	input wire [3:0] chip_sel_n_in,
	// observed outputs
	input wire ext_bus_wait,
	input wire [3:0] chip_sel_pin,
	input wire bus_mode_select,
	input wire cpu_space_mode_select,
	input wire cpu_clock_select,
	input wire fast_osc_enable,
	input wire slow_osc_enable,
	input wire irq_release
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////
	property p_wait_cause; $rose(ext_bus_wait) |-> $past(ext_access_start); endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("wait without start");
	property p_wait_tick; $fell(ext_bus_wait) |-> $past(cpu_half_tick); endproperty
	a_wait_tick: assert property (p_wait_tick) else $error("wait ended off tick");
	property p_wait_end; $rose(ext_bus_wait) |-> ##[1:60] !ext_bus_wait; endproperty
	a_wait_end: assert property (p_wait_end) else $error("wait too long");
	property p_sel_fast; $rose(cpu_clock_select) |-> $past(fast_osc_enable); endproperty
	a_sel_fast: assert property (p_sel_fast) else $error("fast select while off");
	property p_sel_slow; $fell(cpu_clock_select) |-> $past(slow_osc_enable); endproperty
	a_sel_slow: assert property (p_sel_slow) else $error("slow select while off");
	property p_fast_keep; $fell(fast_osc_enable) |-> !$past(cpu_clock_select); endproperty
	a_fast_keep: assert property (p_fast_keep) else $error("fast osc stopped in use");
	property p_slow_keep;
		$fell(slow_osc_enable) |-> $past(cpu_clock_select) && !$past(watchdog_enable);
	endproperty
	a_slow_keep: assert property (p_slow_keep) else $error("slow osc stopped in use");
	property p_irq_hold; irq_release |=> irq_release; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq release dropped");
	// two edges after release the strap has been taken
	property p_reset_mode;
		!$past(hresetn, 2) && $past(hresetn) |-> bus_mode_select == !int_rom_strap
			&& !cpu_space_mode_select && cpu_clock_select && !irq_release;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("bad reset mode");
	property p_mpu_bus; !int_rom_strap && $past(hresetn, 2) |-> bus_mode_select; endproperty
	a_mpu_bus: assert property (p_mpu_bus) else $error("single chip in ext mode");
	property p_mpu_ce0;
		!int_rom_strap && $past(hresetn, 3) |-> chip_sel_pin[0] == $past(chip_sel_n_in[0]);
	endproperty
	a_mpu_ce0: assert property (p_mpu_ce0) else $error("first chip enable lost");
endmodule
bind bcc_top bcc_top_assertions chk_u (.hclk(hclk), .hresetn(hresetn),
	.int_rom_strap(int_rom_strap), .watchdog_enable(watchdog_enable),
	.ext_access_start(ext_access_start), .cpu_half_tick(cpu_half_tick),
	.chip_sel_n_in(chip_sel_n_in), .ext_bus_wait(ext_bus_wait), .chip_sel_pin(chip_sel_pin),
	.bus_mode_select(bus_mode_select), .cpu_space_mode_select(cpu_space_mode_select),
	.cpu_clock_select(cpu_clock_select), .fast_osc_enable(fast_osc_enable),
	.slow_osc_enable(slow_osc_enable), .irq_release(irq_release));
`default_nettype wire

//--- verification/bcc_ext_cycle.sv
`timescale 1ns/10ps
`default_nettype none
// far side of the external bus: half ticks, access starts, wait tally
module bcc_ext_cycle (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// bench control
	input wire go,
	output logic [4:0] ticks,
	output logic done,
	// bus cycle pins
	input wire bus_wait,
	output logic access_start,
	output logic half_tick
);
	logic pend;
	logic armed;
	// start on a cycle without a tick so none is lost at the start edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{pend, armed, done, access_start, half_tick} <= 5'h00;
			ticks <= 5'h00;
		end else begin
			half_tick <= ~half_tick;
			access_start <= pend & half_tick;
			pend <= go | (pend & ~half_tick);
			armed <= (armed | access_start) & ~done;
			if (go) begin
				done <= 1'b0;
				ticks <= 5'h00;
			end else if (bus_wait & half_tick) begin
				ticks <= ticks + 5'h01;
			end
			if (armed & ~bus_wait) done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- verification/bcc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.vh"
module bcc_top_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic strap = 1'b1;
	logic wdog = 1'b0;
	logic go = 1'b0;
	logic [3:0] ce_n = 4'h3;
	// port data is the inverse of the chip enables so every pin shows which source it follows
	logic [3:0] port = 4'hC;
	logic [31:0] rd;
	wire hreadyout, hresp, ext_start, half_tick, ext_wait, done, bus_m, cpu_m, sel, fast, slow, irq;
	wire [31:0] hrdata;
	wire [3:0] pins;
	wire [4:0] ticks;
	int n_fail = 0;
	int checked = 0;
	bcc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .int_rom_strap(strap), .watchdog_enable(wdog),
		.ext_access_start(ext_start), .cpu_half_tick(half_tick), .ext_bus_wait(ext_wait),
		.chip_sel_n_in(ce_n), .general_output_port_pins(port), .chip_sel_pin(pins),
		.bus_mode_select(bus_m), .cpu_space_mode_select(cpu_m), .cpu_clock_select(sel),
		.fast_osc_enable(fast), .slow_osc_enable(slow), .irq_release(irq));
	bcc_ext_cycle far_u (.hclk(hclk), .hresetn(hresetn), .go(go), .ticks(ticks), .done(done),
		.bus_wait(ext_wait), .access_start(ext_start), .half_tick(half_tick));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// hold a phase until hready is seen high; sampled mid-cycle to stay off the edge
	task automatic phase;
		int n;
		logic rdy;
		n = 0;
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end while (!rdy && n < 20);
		if (!rdy) begin
			n_fail++;
			print_verdict();
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		htrans <= `BCC_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		phase();
		htrans <= 2'h0;
		hwdata <= d;
		phase();
	endtask
	task automatic do_reset(input logic s);
		hresetn <= 1'b0;
		strap <= s;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic sc_reset_vals;
		logic [31:0] a[4] = '{`BCC_ADDR_MODE, `BCC_ADDR_WCLK, `BCC_ADDR_STAT, 32'h0000FF0C};
		logic [31:0] e[4] = '{32'h0, 32'h7, 32'h0, 32'h0};
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, a[i], 32'h0);
			chk(rd, e[i]);
			chk(32'(hresp), 32'(`BCC_HRESP_OKAY)); // bus never errors
		end
	endtask
	task automatic sc_irq;
		ahb(1'b1, `BCC_ADDR_MODE, 32'h0);
		repeat (2) @(posedge hclk);
		chk(32'(irq), 32'h0);
		ahb(1'b1, `BCC_ADDR_WCLK, 32'h0F);
		repeat (2) @(posedge hclk);
		chk(32'(irq), 32'h1);
		ahb(1'b0, `BCC_ADDR_WCLK, 32'h0);
		chk(rd, 32'h07);
	endtask
	// each step leans on the interlock state that the step before left
	task automatic sc_clock;
		logic [7:0] w[9] = '{8'h74, 8'h00, 8'h01, 8'h01, 8'h01, 8'h05, 8'h03, 8'h07, 8'h06};
		logic [7:0] e[9] = '{8'h76, 8'h06, 8'h07, 8'h03, 8'h01, 8'h01, 8'h03, 8'h07, 8'h07};
		for (int i = 0; i < 9; i++) begin
			wdog <= (i == 8);
			ahb(1'b1, `BCC_ADDR_WCLK, {24'h0, w[i]});
			ahb(1'b0, `BCC_ADDR_WCLK, 32'h0);
			chk(rd, {24'h0, e[i]});
			chk(32'({sel, fast, slow}), {29'h0, e[i][2:0]});
		end
		wdog <= 1'b0;
	endtask
	task automatic sc_wait;
		int n;
		for (int c = 0; c < 8; c++) begin
			ahb(1'b1, `BCC_ADDR_WCLK, 32'(c * 16 + 7));
			go <= 1'b1;
			@(posedge hclk);
			go <= 1'b0;
			n = 0;
			do begin
				@(negedge hclk);
				n++;
			end while ((!done || n < 2) && n < 80);
			chk(32'(ticks), 32'(2 * c));
			// a cycle that never ends is a mismatch of its own
			if (!done) begin
				n_fail++;
				print_verdict();
			end
			@(posedge hclk);
		end
	endtask
	task automatic sc_modes;
		ahb(1'b1, `BCC_ADDR_MODE, 32'hC6);
		ahb(1'b0, `BCC_ADDR_MODE, 32'h0);
		chk(rd, 32'hC6);
		chk(32'({bus_m, cpu_m}), 32'h3);
		repeat (2) @(posedge hclk);
		chk(32'(pins), 32'((4'h6 & ce_n) | (~4'h6 & port)));
		do_reset(1'b0);
		ahb(1'b0, `BCC_ADDR_MODE, 32'h0);
		chk(rd, 32'h81);
		ahb(1'b1, `BCC_ADDR_MODE, 32'h00);
		ahb(1'b0, `BCC_ADDR_MODE, 32'h0);
		chk(rd, 32'h81);
		// only one register written since reset: interrupts still held, strap seen
		ahb(1'b0, `BCC_ADDR_STAT, 32'h0);
		chk(rd, 32'h02);
	endtask
	initial begin
		forever #25 hclk = ~hclk;
	end
	initial begin
		do_reset(1'b1);
		sc_reset_vals();
		sc_irq();
		sc_clock();
		sc_wait();
		sc_modes();
		print_verdict();
	end
endmodule
`default_nettype wire
